// >>> inc/irq_event_map.svh
// Address map, field positions, reset values of the event/mask block
`ifndef IRQ_EVENT_MAP_SVH
`define IRQ_EVENT_MAP_SVH

`define APB_ADDR_W 12
`define EVT_W 22

`define EVT_SET_OFS 12'h080
`define EVT_CLR_OFS 12'h084
`define MSK_SET_OFS 12'h088
`define MSK_CLR_OFS 12'h08C

`define BIT_CYC64 21
`define BIT_CYC_SYNC 20
`define BIT_PHY_REQ 19
`define BIT_LINK_RESET 17
`define BIT_NODE_ID_DONE 16
`define BIT_ATOMIC_ERR 9
`define BIT_BUF_WR_ERR 8
`define BIT_ISO_RX 7
`define BIT_ISO_TX 6
`define BIT_RSP_PKT 5
`define BIT_REQ_PKT 4
`define BIT_ARX_RSP 3
`define BIT_ARX_REQ 2
`define BIT_ATX_RSP 1
`define BIT_ATX_REQ 0
`define BIT_GLOBAL_EN 31

`define EVT_LATCHED 22'h3B033F
`define EVT_READABLE 22'h3B03FF
`define MSK_WRITABLE 22'h3B03FF

`define EVT_RESET 22'h000000
`define MSK_RESET 22'h000000
`define GEN_RESET 1'b0
`define RDATA_RESET 32'h00000000

`endif

// >>> inc/irq_event_pkg.sv
// Types shared by the event/mask block
package irq_event_pkg;

  typedef enum logic [2:0] {
    SEL_EVT_SET,
    SEL_EVT_CLR,
    SEL_MSK_SET,
    SEL_MSK_CLR,
    SEL_NONE
  } reg_sel_e;

  typedef struct packed {
    logic cycle_second_bit7;
    logic cycle_count_lsb;
    logic phy_status_irq;
    logic link_reset_entered;
    logic node_id_stream_done;
    logic atomic_reply_unacked;
    logic buffered_write_host_fault;
    logic response_packet_stored;
    logic request_packet_stored;
    logic async_rx_response_ctx;
    logic async_rx_request_ctx;
    logic response_send_done;
    logic request_send_done;
  } event_sources_s;

endpackage : irq_event_pkg

// >>> logic/event_flag_bank.sv
// Bank of sticky flags with set, clear and overriding kill per bit
`timescale 1ns/10ps
module event_flag_bank #(
  parameter int WIDTH = 22,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] set_bits,
  input wire logic [WIDTH-1:0] clr_bits,
  input wire logic [WIDTH-1:0] kill_bits,
  output logic [WIDTH-1:0] flags_q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      // Set beats clear so a coinciding event survives; kill beats both
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags_q[i] <= RESET_VAL[i];
        end else if (kill_bits[i]) begin
          flags_q[i] <= 1'b0;
        end else if (set_bits[i]) begin
          flags_q[i] <= 1'b1;
        end else if (clr_bits[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : event_flag_bank

// >>> logic/irq_event_core.sv
// Interrupt event and mask registers with APB access and interrupt output
`timescale 1ns/10ps
`include "irq_event_map.svh"

// What this block does
// - Bit 21 sets on cycle-second bit 7 change
// - Bit 20 sets on cycle-count LSB toggle
// - Bit 19 sets on PHY status interrupt
// - Bits 18 and 15..10 read zero
// - Bit 17 sets on bus reset entry
// - Bit 16 sets on self-ID stream done
// - Bus reset setting clears bit 16 together
// - Bit 9 sets on unacked lock response
// - Bit 8 sets on posted write host error
// - Bit 7 is ORed masked iso-rx events
// - Bit 6 is ORed masked iso-tx events
// - Bit 5 sets on response packet stored
// - Bit 4 sets on request packet stored
// - Bit 3 sets on rx response context completion
// - Bit 2 sets on rx request context completion
// - Bit 1 sets on tx response completion
// - Bit 0 sets on tx request completion
// - Rising source edge (either edge for bits 21 and 20) or set-write sets bit
// - Clear-register write of one clears; bus reset setting also clears bit 16
// - Global enable low blocks the interrupt
module irq_event_core #(
  parameter int ISO_RX_CTX = 4,
  parameter int ISO_TX_CTX = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input irq_event_pkg::event_sources_s sources,
  input wire logic [ISO_RX_CTX-1:0] iso_rx_context_events,
  input wire logic [ISO_RX_CTX-1:0] iso_rx_context_enables,
  input wire logic [ISO_TX_CTX-1:0] iso_tx_context_events,
  input wire logic [ISO_TX_CTX-1:0] iso_tx_context_enables,
  output logic irq_out
);

  import irq_event_pkg::*;

  function automatic reg_sel_e decode_sel(input logic [`APB_ADDR_W-1:0] addr);
    case (addr)
      `EVT_SET_OFS: decode_sel = SEL_EVT_SET;
      `EVT_CLR_OFS: decode_sel = SEL_EVT_CLR;
      `MSK_SET_OFS: decode_sel = SEL_MSK_SET;
      `MSK_CLR_OFS: decode_sel = SEL_MSK_CLR;
      default: decode_sel = SEL_NONE;
    endcase
  endfunction : decode_sel

  logic setup_phase;
  logic wr_access;
  logic wr_evt_set;
  logic wr_evt_clr;
  logic wr_msk_set;
  logic wr_msk_clr;
  reg_sel_e sel_now;

  event_sources_s prev_q;
  logic primed_q;

  logic [`EVT_W-1:0] hw_set;
  logic [`EVT_W-1:0] sw_set;
  logic [`EVT_W-1:0] sw_clr;
  logic [`EVT_W-1:0] set_total;
  logic [`EVT_W-1:0] kill_bits;
  logic [`EVT_W-1:0] event_q;
  logic [`EVT_W-1:0] event_view;

  logic [`EVT_W-1:0] msk_set;
  logic [`EVT_W-1:0] msk_clr;
  logic [`EVT_W-1:0] mask_q;
  logic global_irq_enable_q;

  logic iso_receive_summary;
  logic iso_transmit_summary;

  logic [31:0] read_value;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic irq_q;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign irq_out = irq_q;

  assign sel_now = decode_sel(paddr);
  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign wr_evt_set = wr_access & (sel_now == SEL_EVT_SET);
  assign wr_evt_clr = wr_access & (sel_now == SEL_EVT_CLR);
  assign wr_msk_set = wr_access & (sel_now == SEL_MSK_SET);
  assign wr_msk_clr = wr_access & (sel_now == SEL_MSK_CLR);

  // Source history; primed_q keeps the first sample after reset from faking an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= sources;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
    end
  end

  always_comb begin
    hw_set = '0;
    hw_set[`BIT_CYC64] = primed_q & (sources.cycle_second_bit7 ^ prev_q.cycle_second_bit7);
    hw_set[`BIT_CYC_SYNC] = primed_q & (sources.cycle_count_lsb ^ prev_q.cycle_count_lsb);
    hw_set[`BIT_PHY_REQ] = primed_q & sources.phy_status_irq & ~prev_q.phy_status_irq;
    hw_set[`BIT_LINK_RESET] = primed_q & sources.link_reset_entered & ~prev_q.link_reset_entered;
    hw_set[`BIT_NODE_ID_DONE] = primed_q & sources.node_id_stream_done & ~prev_q.node_id_stream_done;
    hw_set[`BIT_ATOMIC_ERR] = primed_q & sources.atomic_reply_unacked & ~prev_q.atomic_reply_unacked;
    hw_set[`BIT_BUF_WR_ERR] = primed_q & sources.buffered_write_host_fault
                              & ~prev_q.buffered_write_host_fault;
    hw_set[`BIT_RSP_PKT] = primed_q & sources.response_packet_stored
                           & ~prev_q.response_packet_stored;
    hw_set[`BIT_REQ_PKT] = primed_q & sources.request_packet_stored & ~prev_q.request_packet_stored;
    // Completion inputs arrive already qualified by the context's own condition
    hw_set[`BIT_ARX_RSP] = primed_q & sources.async_rx_response_ctx & ~prev_q.async_rx_response_ctx;
    hw_set[`BIT_ARX_REQ] = primed_q & sources.async_rx_request_ctx & ~prev_q.async_rx_request_ctx;
    hw_set[`BIT_ATX_RSP] = primed_q & sources.response_send_done & ~prev_q.response_send_done;
    hw_set[`BIT_ATX_REQ] = primed_q & sources.request_send_done & ~prev_q.request_send_done;
  end

  // Software set and clear touch latched bits only
  assign sw_set = wr_evt_set ? (pwdata[`EVT_W-1:0] & `EVT_LATCHED) : '0;
  assign sw_clr = wr_evt_clr ? (pwdata[`EVT_W-1:0] & `EVT_LATCHED) : '0;
  assign set_total = (hw_set | sw_set) & `EVT_LATCHED;

  // Link reset becoming set wipes self-ID done in the same edge, even against its own set
  always_comb begin
    kill_bits = '0;
    kill_bits[`BIT_NODE_ID_DONE] = set_total[`BIT_LINK_RESET] & ~event_q[`BIT_LINK_RESET];
  end

  event_flag_bank #(
    .WIDTH(`EVT_W),
    .RESET_VAL(`EVT_RESET)
  ) u_events (
    .pclk(pclk),
    .presetn(presetn),
    .set_bits(set_total),
    .clr_bits(sw_clr),
    .kill_bits(kill_bits),
    .flags_q(event_q)
  );

  // Summary bits follow the per-context registers live, never latched
  assign iso_receive_summary = |(iso_rx_context_events & iso_rx_context_enables);
  assign iso_transmit_summary = |(iso_tx_context_events & iso_tx_context_enables);

  always_comb begin
    event_view = event_q & `EVT_LATCHED;
    event_view[`BIT_ISO_RX] = iso_receive_summary;
    event_view[`BIT_ISO_TX] = iso_transmit_summary;
  end

  assign msk_set = wr_msk_set ? (pwdata[`EVT_W-1:0] & `MSK_WRITABLE) : '0;
  assign msk_clr = wr_msk_clr ? (pwdata[`EVT_W-1:0] & `MSK_WRITABLE) : '0;

  event_flag_bank #(
    .WIDTH(`EVT_W),
    .RESET_VAL(`MSK_RESET)
  ) u_mask (
    .pclk(pclk),
    .presetn(presetn),
    .set_bits(msk_set),
    .clr_bits(msk_clr),
    .kill_bits('0),
    .flags_q(mask_q)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable_q <= `GEN_RESET;
    end else if (wr_msk_set & pwdata[`BIT_GLOBAL_EN]) begin
      global_irq_enable_q <= 1'b1;
    end else if (wr_msk_clr & pwdata[`BIT_GLOBAL_EN]) begin
      global_irq_enable_q <= 1'b0;
    end
  end

  // Registered to keep the pin glitch-free; costs one cycle of latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= global_irq_enable_q & (|(event_view & mask_q));
    end
  end

  // Clear address reads back the enabled events, not the raw flags
  always_comb begin
    read_value = '0;
    case (sel_now)
      SEL_EVT_SET: begin
        read_value[`EVT_W-1:0] = event_view;
      end
      SEL_EVT_CLR: begin
        read_value[`EVT_W-1:0] = event_view & mask_q;
      end
      SEL_MSK_SET, SEL_MSK_CLR: begin
        read_value[`EVT_W-1:0] = mask_q & `MSK_WRITABLE;
        read_value[`BIT_GLOBAL_EN] = global_irq_enable_q;
      end
      default: begin
        read_value = '0;
      end
    endcase
  end

  // Read data captured in setup so it leaves a flop in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `RDATA_RESET;
    end else if (setup_phase & ~pwrite) begin
      prdata_q <= read_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      pslverr_q <= (sel_now == SEL_NONE);
    end
  end

endmodule : irq_event_core

// >>> tb/irq_event_core_asserts.sv
// Port checker for the event and mask block
`timescale 1ns/10ps
`include "irq_event_map.svh"
module irq_event_core_asserts
  import irq_event_pkg::*;
#(
  parameter int ISO_RX_CTX = 4,
  parameter int ISO_TX_CTX = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input irq_event_pkg::event_sources_s sources,
  input wire logic [ISO_RX_CTX-1:0] iso_rx_context_events,
  input wire logic [ISO_RX_CTX-1:0] iso_rx_context_enables,
  input wire logic [ISO_TX_CTX-1:0] iso_tx_context_events,
  input wire logic [ISO_TX_CTX-1:0] iso_tx_context_enables,
  input wire logic irq_out
);
  logic rd_setup, wr_acc, mapped, iso_any, gen_q;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_acc = psel && penable && pwrite;
  assign mapped = paddr == `EVT_SET_OFS || paddr == `EVT_CLR_OFS || paddr == `MSK_SET_OFS || paddr == `MSK_CLR_OFS;
  assign iso_any = |(iso_rx_context_events & iso_rx_context_enables)
    || |(iso_tx_context_events & iso_tx_context_enables);
  // Shadow of the global enable, seen only through bus writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gen_q <= 1'b0;
    else if (wr_acc && pwdata[31] && paddr == `MSK_SET_OFS) gen_q <= 1'b1;
    else if (wr_acc && pwdata[31] && paddr == `MSK_CLR_OFS) gen_q <= 1'b0;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_unmapped_err: assert property (psel && !penable && !mapped |=> pslverr) else $error("no slave error");
  a_unmapped_zero: assert property (rd_setup && !mapped |=> prdata == 32'h00000000) else $error("unmapped data");
  a_reserved_zero:
    assert property (rd_setup && paddr == `EVT_SET_OFS |=> prdata[31:22] == 10'h000 && !prdata[18]
      && prdata[15:10] == 6'h00) else $error("reserved bit set");
  a_iso_rx_live:
    assert property (rd_setup && paddr == `EVT_SET_OFS |=> prdata[7] == $past(|(iso_rx_context_events
      & iso_rx_context_enables))) else $error("iso rx summary");
  a_iso_tx_live:
    assert property (rd_setup && paddr == `EVT_SET_OFS |=> prdata[6] == $past(|(iso_tx_context_events
      & iso_tx_context_enables))) else $error("iso tx summary");
  a_enable_read:
    assert property (rd_setup && paddr == `MSK_SET_OFS |=> prdata[31] == $past(gen_q)) else $error("enable read");
  a_global_off_quiet: assert property (!$past(gen_q) |-> !irq_out) else $error("irq while disabled");
  a_irq_drop_cause:
    assert property ($fell(irq_out) |-> $past(wr_acc && mapped, 2) || $past(iso_any, 2)
      || $past(sources.link_reset_entered, 2)) else $error("irq fell without cause");
  c_clear_write: cover property (wr_acc && paddr == `EVT_CLR_OFS);
  c_irq_rise: cover property ($rose(irq_out));
  c_unmapped: cover property (rd_setup && !mapped);
endmodule : irq_event_core_asserts

bind irq_event_core irq_event_core_asserts #(.ISO_RX_CTX(ISO_RX_CTX), .ISO_TX_CTX(ISO_TX_CTX)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sources(sources),
  .iso_rx_context_events(iso_rx_context_events), .iso_rx_context_enables(iso_rx_context_enables),
  .iso_tx_context_events(iso_tx_context_events), .iso_tx_context_enables(iso_tx_context_enables),
  .irq_out(irq_out));

// >>> tb/tb_top.sv
// Self-checking bench for the event and mask block
`timescale 1ns/10ps
`include "irq_event_map.svh"
module tb_top;
  import irq_event_pkg::*;
  localparam int BP [13] = '{0, 1, 2, 3, 4, 5, 8, 9, 16, 17, 19, 20, 21};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq_out, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, d, c, m, ev;
  logic [3:0] rxe = '0, rxn = '0;
  logic [7:0] txe = '0, txn = '0;
  event_sources_s src = '0;
  int seed = 92816, miscompares = 0, n_compared = 0, cycles = 0;
  irq_event_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sources(src),
    .iso_rx_context_events(rxe), .iso_rx_context_enables(rxn), .iso_tx_context_events(txe),
    .iso_tx_context_enables(txn), .irq_out(irq_out));
  always #50 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // Set write raising bit 17 wipes bit 16 in the same edge; assumes bit 17 was clear before
  function automatic logic [31:0] exp_events(input logic [31:0] set_w, input logic [31:0] clr_w);
    exp_events = set_w & ~clr_w & `EVT_LATCHED & ~(32'(set_w[`BIT_LINK_RESET]) << `BIT_NODE_ID_DONE);
    exp_events[`BIT_ISO_RX] = |(rxe & rxn);
    exp_events[`BIT_ISO_TX] = |(txe & txn);
  endfunction : exp_events
  // One APB transfer; result lands in rd and err
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic summarize();
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      xfer(1'b0, `EVT_SET_OFS + 12'(4 * a), '0);
      chk(rd, '0);
    end
    xfer(1'b1, 12'h090, '1);
    xfer(1'b0, 12'h090, '0);
    chk({rd[30:0], err}, 32'h1);
    // Non-toggle sources must not re-set while held or on their fall
    for (int i = 0; i < 13; i++) begin
      src[i] <= ~src[i];
      xfer(1'b0, `EVT_SET_OFS, '0);
      chk(rd, 32'(1) << BP[i]);
      xfer(1'b1, `EVT_CLR_OFS, 32'(1) << BP[i]);
      src[i] <= ~src[i];
      xfer(1'b0, `EVT_SET_OFS, '0);
      chk(rd, i > 10 ? 32'(1) << BP[i] : '0);
      xfer(1'b1, `EVT_CLR_OFS, 32'(1) << BP[i]);
    end
    xfer(1'b1, `EVT_SET_OFS, 32'h00010000);
    src.link_reset_entered <= 1'b1;
    xfer(1'b0, `EVT_SET_OFS, '0);
    chk(rd, 32'h00020000);
    xfer(1'b1, `EVT_CLR_OFS, '1);
    src.link_reset_entered <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      rxe <= 4'($random(seed));
      rxn <= 4'($random(seed));
      txe <= 8'($random(seed));
      txn <= 8'($random(seed));
      d = $random(seed);
      c = $random(seed);
      m = $random(seed);
      xfer(1'b1, `EVT_SET_OFS, d);
      xfer(1'b1, `EVT_CLR_OFS, c);
      xfer(1'b1, `MSK_SET_OFS, m);
      ev = exp_events(d, c);
      xfer(1'b0, `EVT_SET_OFS, '0);
      chk(rd, ev);
      xfer(1'b0, `MSK_CLR_OFS, '0);
      chk(rd, m & 32'h803B03FF);
      xfer(1'b0, `EVT_CLR_OFS, '0);
      chk(rd, ev & m & 32'h003FFFFF);
      #1;
      chk(32'(irq_out), 32'(m[31] && |(ev[21:0] & m[21:0])));
      xfer(1'b1, `EVT_CLR_OFS, '1);
      xfer(1'b1, `MSK_CLR_OFS, '1);
    end
    rxe <= '0;
    txe <= '0;
    xfer(1'b1, `MSK_SET_OFS, 32'h1);
    xfer(1'b1, `EVT_SET_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(irq_out), '0);
    xfer(1'b1, `MSK_SET_OFS, 32'h80000000);
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(irq_out), 32'h1);
    xfer(1'b1, `EVT_CLR_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(irq_out), '0);
    summarize();
  end
endmodule : tb_top
